// file: src/deb_cfg.svh
// deb_cfg.svh: constants of the dual elastic buffer
// assumes inclusion by bare name; holds definitions only
// Contract
// R1: two independent bit buffers run at once, one from side A to side B and one back.
// R2: each buffer is 512 or 64 bits deep, and both buffers of one instance share that depth.
// R3: on overflow or underflow a buffer re-centres its fill to half its depth and goes on.
// R4: side A receive data is written into the A-to-B buffer one bit per side A receive clock.
// R5: the A-to-B buffer is read onto side B transmit data one bit per side B transmit clock.
// R6: side B receive data is written into the B-to-A buffer one bit per side B receive clock.
// R7: the B-to-A buffer is read onto side A transmit data one bit per side A transmit clock.
// R8: in the X.21 variant each side gives one timing clock, used for both writing and reading.
// R9: only data is buffered; control lines pass straight across with no added delay.
// R10: the bit stream is moved unchanged, with no framing or protocol interpretation.
// R11: bit rates stay at or below the maximum rate on each side.
// R12: after reset each buffer starts with read and write positions half a buffer apart.
`ifndef DEB_CFG_SVH
`define DEB_CFG_SVH

// buffer depths in bits
`define DEB_BUF_BITS 32'h0000_0200
`define DEB_BUF_BITS_SMALL 32'h0000_0040

// words in the mclk-side staging fifo
`define DEB_FIFO_DEPTH 32'h0000_0004

// highest bit rate on either side, in bits per second
`define DEB_MAX_RATE_BPS 32'h0000_0800

// mclk rate in hertz
`define DEB_MCLK_HZ 32'h05F5_E100

// width of the control line bundle on each side
`define DEB_CTL_W 32'h0000_0004

// level of an idle serial data line (mark)
`define DEB_IDLE_BIT 1'h1

`endif

// file: src/deb_pkg.sv
// deb_pkg.sv: types of the dual elastic buffer
// assumes nothing beyond a SystemVerilog compiler
package deb_pkg;

    // operation done on a bit store in one mclk cycle
    typedef enum logic [1:0] {
        DEB_IDLE,
        DEB_WRITE,
        DEB_READ
    } deb_op_type;

    // one data bit travelling through the staging fifo
    typedef struct packed {
        logic data;
    } deb_bit_type;

    // re-centre events of one buffer
    typedef struct packed {
        logic ovf;
        logic unf;
    } deb_slip_type;

endpackage

// file: src/deb_fifo.sv
// deb_fifo.sv: small synchronous fifo with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
`include "deb_cfg.svh"

module deb_fifo
    import deb_pkg::*;
#(
    parameter int W = $bits(deb_bit_type),
    parameter int DEPTH = `DEB_FIFO_DEPTH
)
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [CW-1:0] cnt_q;
    logic push;
    logic pop;

    // step a pointer, wrapping at the last slot
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    // honest full and empty from the word count
    assign in_ready_o = (cnt_q != FULL);
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rp_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // storage
    always_ff @(posedge mclk_i)
    begin
        if (push)
        begin
            mem_q[wp_q] <= in_data_i;
        end
    end

    // pointers and count
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_q <= bump(wp_q);
            end
            if (pop)
            begin
                rp_q <= bump(rp_q);
            end
            if (push && !pop)
            begin
                cnt_q <= CW'(cnt_q + 1'b1);
            end
            else if (pop && !push)
            begin
                cnt_q <= CW'(cnt_q - 1'b1);
            end
        end
    end

endmodule
`default_nettype wire

// file: src/deb_dual_elastic_buffer.sv
// deb_dual_elastic_buffer.sv: full-duplex elastic buffer joining two DCE ports
// assumes bit clocks far slower than mclk_i, and mclk_i running whenever data moves
`timescale 1ns/1ps
`default_nettype none
`include "deb_cfg.svh"

module deb_dual_elastic_buffer
    import deb_pkg::*;
#(
    parameter int BUF_BITS = `DEB_BUF_BITS,
    parameter bit X21_MODE = 1'b0,
    parameter int CTL_W = `DEB_CTL_W
)
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic rx_clk_a_i,
    input wire logic tx_clk_a_i,
    input wire logic rx_clk_b_i,
    input wire logic tx_clk_b_i,
    input wire logic rxd_a_i,
    input wire logic rxd_b_i,
    output logic txd_a_o,
    output logic txd_b_o,
    input wire logic [CTL_W-1:0] ctl_a_i,
    input wire logic [CTL_W-1:0] ctl_b_i,
    output logic [CTL_W-1:0] ctl_a_o,
    output logic [CTL_W-1:0] ctl_b_o,
    output var deb_slip_type slip_ab_o,
    output var deb_slip_type slip_ba_o,
    output logic [$clog2(BUF_BITS):0] level_ab_o,
    output logic [$clog2(BUF_BITS):0] level_ba_o
);

    // store geometry; depth is a power of two so pointers wrap by themselves
    localparam int AW = $clog2(BUF_BITS); // [R2]
    localparam logic [AW-1:0] HALF = AW'(BUF_BITS / 2);
    localparam logic [AW:0] FULL = (AW + 1)'(BUF_BITS);
    localparam logic [AW:0] MID = {1'b0, HALF};

    // per-direction views: index 0 is A to B, index 1 is B to A
    logic [1:0] wclk;
    logic [1:0] rclk;
    logic [1:0] rxd;
    logic [1:0] txd;
    deb_slip_type slip [2];
    logic [AW:0] lvl [2];

    // pointer that lies n bits behind p, modulo the store depth
    function automatic logic [AW-1:0] ptr_back(input logic [AW-1:0] p, input logic [AW-1:0] n);
        ptr_back = AW'(p - n);
    endfunction

    // write clocks are the receive clocks, read clocks the far side's transmit clocks, or its receive clocks in X21_MODE
    assign wclk[0] = rx_clk_a_i; // [R4]
    assign wclk[1] = rx_clk_b_i; // [R6]
    assign rclk[0] = X21_MODE ? rx_clk_b_i : tx_clk_b_i; // [R5] [R8]
    assign rclk[1] = X21_MODE ? rx_clk_a_i : tx_clk_a_i; // [R7] [R8]
    assign rxd[0] = rxd_a_i;
    assign rxd[1] = rxd_b_i;

    // data leaves on the far side's transmit line
    assign txd_b_o = txd[0]; // [R5]
    assign txd_a_o = txd[1]; // [R7]
    assign slip_ab_o = slip[0];
    assign slip_ba_o = slip[1];
    assign level_ab_o = lvl[0];
    assign level_ba_o = lvl[1];

    // control lines are wired through, ahead of the buffered data
    assign ctl_b_o = ctl_a_i; // [R9]
    assign ctl_a_o = ctl_b_i; // [R9]

    // two identical, independent directions
    for (genvar d = 0; d < 2; d++)
    begin : g_dir // [R1]
        logic in_bit_q;
        logic in_tog_q;
        logic [2:0] in_sync_q;
        logic in_evt;
        logic pend_q;
        logic pend_bit_q;
        deb_bit_type fifo_in;
        deb_bit_type fifo_out;
        logic fifo_in_rdy;
        logic fifo_out_vld;
        logic fifo_out_rdy;
        logic [BUF_BITS-1:0] mem_q;
        logic [AW-1:0] wr_q;
        logic [AW-1:0] rd_q;
        logic [AW:0] fill_q;
        logic nb_q;
        logic out_tog_q;
        logic [2:0] out_sync_q;
        logic out_evt;
        logic txd_q;
        deb_slip_type slip_q;
        logic [AW:0] lvl_q;
        deb_op_type op;

        // receive side: capture each bit on the write clock and flag it by a toggle
        always_ff @(posedge wclk[d] or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                in_bit_q <= `DEB_IDLE_BIT;
                in_tog_q <= 1'b0;
            end
            else
            begin
                in_bit_q <= rxd[d]; // [R4] [R6] [R10]
                in_tog_q <= ~in_tog_q;
            end
        end

        // bring the receive toggle into mclk; stage 0 feeds stage 1 only
        always_ff @(posedge mclk_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                in_sync_q <= '0;
            end
            else
            begin
                in_sync_q <= {in_sync_q[1:0], in_tog_q};
            end
        end

        // the captured bit has been stable for two mclk edges when the toggle lands
        assign in_evt = in_sync_q[2] ^ in_sync_q[1]; // [R11]

        // hold the arrived bit until the fifo takes it; a new arrival wins
        always_ff @(posedge mclk_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                pend_q <= 1'b0;
                pend_bit_q <= `DEB_IDLE_BIT;
            end
            else if (in_evt)
            begin
                pend_q <= 1'b1;
                pend_bit_q <= in_bit_q;
            end
            else if (fifo_in_rdy)
            begin
                pend_q <= 1'b0;
            end
        end

        assign fifo_in.data = pend_bit_q;

        // staging fifo between the receive crossing and the bit store
        deb_fifo #(
            .W($bits(deb_bit_type)),
            .DEPTH(`DEB_FIFO_DEPTH)
        ) u_stage (
            .mclk_i(mclk_i),
            .arst_n_i(arst_n_i),
            .in_valid_i(pend_q),
            .in_ready_o(fifo_in_rdy),
            .in_data_i(fifo_in),
            .out_valid_o(fifo_out_vld),
            .out_ready_i(fifo_out_rdy),
            .out_data_o(fifo_out)
        );

        // bring the transmit toggle into mclk; stage 0 feeds stage 1 only
        always_ff @(posedge mclk_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                out_sync_q <= '0;
            end
            else
            begin
                out_sync_q <= {out_sync_q[1:0], out_tog_q};
            end
        end

        assign out_evt = out_sync_q[2] ^ out_sync_q[1];

        // one store access per cycle: a read goes first and the fifo waits
        always_comb
        begin
            op = DEB_IDLE;
            if (out_evt)
            begin
                op = DEB_READ;
            end
            else if (fifo_out_vld)
            begin
                op = DEB_WRITE;
            end
        end

        assign fifo_out_rdy = (op == DEB_WRITE);

        // pointers and fill; both slips put the fill back at mid-store
        always_ff @(posedge mclk_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                wr_q <= HALF; // [R12]
                rd_q <= '0; // [R12]
                fill_q <= MID; // [R12]
            end
            else
            begin
                case (op)
                    DEB_WRITE:
                    begin
                        wr_q <= AW'(wr_q + 1'b1); // [R4] [R6]
                        if (fill_q == FULL)
                        begin
                            rd_q <= ptr_back(AW'(wr_q + 1'b1), HALF); // [R3]
                            fill_q <= MID; // [R3]
                        end
                        else
                        begin
                            fill_q <= (AW + 1)'(fill_q + 1'b1);
                        end
                    end
                    DEB_READ:
                    begin
                        if (fill_q == '0)
                        begin
                            rd_q <= ptr_back(wr_q, HALF); // [R3]
                            fill_q <= MID; // [R3]
                        end
                        else
                        begin
                            rd_q <= AW'(rd_q + 1'b1); // [R5] [R7]
                            fill_q <= (AW + 1)'(fill_q - 1'b1);
                        end
                    end
                    default:
                    begin
                        fill_q <= fill_q;
                    end
                endcase
            end
        end

        // bit store, preset to idle line level
        always_ff @(posedge mclk_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                mem_q <= {BUF_BITS{`DEB_IDLE_BIT}}; // [R12]
            end
            else if (op == DEB_WRITE)
            begin
                mem_q[wr_q] <= fifo_out.data; // [R10]
            end
        end

        // next bit to send; on underflow the last bit is repeated once
        always_ff @(posedge mclk_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                nb_q <= `DEB_IDLE_BIT;
            end
            else if (op == DEB_READ && fill_q != '0)
            begin
                nb_q <= mem_q[rd_q]; // [R5] [R7]
            end
        end

        // slip pulses and fill level for the outside
        always_ff @(posedge mclk_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                slip_q <= '0;
                lvl_q <= MID;
            end
            else
            begin
                slip_q.ovf <= (op == DEB_WRITE) && (fill_q == FULL); // [R3]
                slip_q.unf <= (op == DEB_READ) && (fill_q == '0); // [R3]
                lvl_q <= fill_q;
            end
        end

        // transmit side: launch on the falling read clock edge, then ask for the next bit
        always_ff @(negedge rclk[d] or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                txd_q <= `DEB_IDLE_BIT;
                out_tog_q <= 1'b0;
            end
            else
            begin
                txd_q <= nb_q; // [R5] [R7] [R11]
                out_tog_q <= ~out_tog_q;
            end
        end

        assign txd[d] = txd_q;
        assign slip[d] = slip_q;
        assign lvl[d] = lvl_q;
    end

endmodule
`default_nettype wire

// file: verification/deb_dual_elastic_buffer_asserts.sv
// checker: relations between the elastic buffer's ports in the mclk domain
// assumes binding to every buffer instance; link edges far apart in mclk terms
`timescale 1ns/1ps
`default_nettype none

module deb_dual_elastic_buffer_asserts
    import deb_pkg::*;
#(
    parameter int BUF_BITS = 512,
    parameter int CTL_W = 4
)
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [CTL_W-1:0] ctl_a_i,
    input wire logic [CTL_W-1:0] ctl_b_i,
    input wire logic [CTL_W-1:0] ctl_a_o,
    input wire logic [CTL_W-1:0] ctl_b_o,
    input wire deb_slip_type slip_ab_o,
    input wire deb_slip_type slip_ba_o,
    input wire logic [$clog2(BUF_BITS):0] level_ab_o,
    input wire logic [$clog2(BUF_BITS):0] level_ba_o
);
    localparam int HALF = BUF_BITS / 2;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    // control lines cross with no delay
    a_ctl_ab_pass: assert property (ctl_b_o == ctl_a_i)
        else $error("ctl_b_o does not follow ctl_a_i");
    a_ctl_ba_pass: assert property (ctl_a_o == ctl_b_i)
        else $error("ctl_a_o does not follow ctl_b_i");
    // a slip leaves the fill at half depth; the level flop lags one cycle
    a_ovf_ab_centre: assert property (slip_ab_o.ovf |-> ##[1:3] level_ab_o == HALF)
        else $error("a to b fill not centred after overflow");
    a_unf_ab_centre: assert property (slip_ab_o.unf |-> ##[1:3] level_ab_o == HALF)
        else $error("a to b fill not centred after underflow");
    a_ovf_ba_centre: assert property (slip_ba_o.ovf |-> ##[1:3] level_ba_o == HALF)
        else $error("b to a fill not centred after overflow");
    a_unf_ba_centre: assert property (slip_ba_o.unf |-> ##[1:3] level_ba_o == HALF)
        else $error("b to a fill not centred after underflow");
    // slip flags are single-cycle pulses
    a_slip_ab_pulse: assert property (slip_ab_o != 2'h0 |=> slip_ab_o == 2'h0)
        else $error("a to b slip longer than one cycle");
    a_slip_ba_pulse: assert property (slip_ba_o != 2'h0 |=> slip_ba_o == 2'h0)
        else $error("b to a slip longer than one cycle");
    // fill never exceeds the configured depth
    a_level_ab_bound: assert property (level_ab_o <= BUF_BITS)
        else $error("a to b fill above depth");
    a_level_ba_bound: assert property (level_ba_o <= BUF_BITS)
        else $error("b to a fill above depth");
    // both buffers leave reset half full
    a_reset_centre: assert property ($rose(arst_n_i) |-> level_ab_o == HALF && level_ba_o == HALF)
        else $error("fill not at half depth after reset");
endmodule

bind deb_dual_elastic_buffer deb_dual_elastic_buffer_asserts #(
    .BUF_BITS(BUF_BITS),
    .CTL_W(CTL_W)
) chk_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ctl_a_i(ctl_a_i), .ctl_b_i(ctl_b_i),
    .ctl_a_o(ctl_a_o), .ctl_b_o(ctl_b_o), .slip_ab_o(slip_ab_o), .slip_ba_o(slip_ba_o),
    .level_ab_o(level_ab_o), .level_ba_o(level_ba_o));

`default_nettype wire

// file: verification/deb_dce_model.sv
// model of one dce port: bit clocks, receive data out, transmit data sampled
// assumes the bench starts and stops the clocks between bursts
`timescale 1ns/1ps
`default_nettype none

module deb_dce_model #(
    parameter int HALF_NS = 24,
    parameter logic [15:0] PAT = 16'hA5C3
)
(
    input wire logic run_rx_i,
    input wire logic run_tx_i,
    output logic rx_clk_o,
    output logic tx_clk_o,
    output logic rxd_o,
    input wire logic txd_i
);
    logic sent[$];
    logic got[$];
    int n = 0;
    initial rx_clk_o = 1'b0;
    initial tx_clk_o = 1'b1;
    initial rxd_o = PAT[0];
    // clocks stand still outside bursts: receive rests low, transmit rests high
    always #(HALF_NS) rx_clk_o = run_rx_i ? ~rx_clk_o : 1'b0;
    always #(HALF_NS) tx_clk_o = run_tx_i ? ~tx_clk_o : 1'b1;
    // new data after each falling edge, held across the rising sampling edge
    always @(negedge rx_clk_o)
    begin
        n = n + 1;
        rxd_o <= PAT[n % 16];
    end
    // record what the device takes and what it sends
    always @(posedge rx_clk_o) sent.push_back(rxd_o);
    always @(posedge tx_clk_o) got.push_back(txd_i);
endmodule

`default_nettype wire

// file: verification/deb_dual_elastic_buffer_tb.sv
// bench for the dual elastic buffer with a dce model on each side
// assumes the small 64-bit depth so slips come quickly
`timescale 1ns/1ps
`default_nettype none

module deb_dual_elastic_buffer_tb;
    import deb_pkg::*;
    localparam int BB = 64;
    localparam int HB = BB / 2;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] ctl_a = 4'h0;
    logic [3:0] ctl_b = 4'h0;
    logic [3:0] ctl_a_q;
    logic [3:0] ctl_b_q;
    logic run_rx_a = 1'b0;
    logic run_tx_a = 1'b0;
    logic run_rx_b = 1'b0;
    logic run_tx_b = 1'b0;
    logic rxc_a, txc_a, rxc_b, txc_b, rxd_a, rxd_b, txd_a, txd_b;
    deb_slip_type slip_ab, slip_ba;
    logic [6:0] level_ab, level_ba;
    logic [3:0] slip_all;
    logic txd_xa, txd_xb;
    logic got_xa[$];
    logic got_xb[$];
    int slips[4];
    int miscompares = 0;
    int cmp_count = 0;

    always #5 mclk = ~mclk;

    deb_dual_elastic_buffer #(.BUF_BITS(BB), .X21_MODE(1'b0), .CTL_W(4)) dut_u (
        .mclk_i(mclk), .arst_n_i(arst_n), .rx_clk_a_i(rxc_a), .tx_clk_a_i(txc_a),
        .rx_clk_b_i(rxc_b), .tx_clk_b_i(txc_b), .rxd_a_i(rxd_a), .rxd_b_i(rxd_b),
        .txd_a_o(txd_a), .txd_b_o(txd_b), .ctl_a_i(ctl_a), .ctl_b_i(ctl_b),
        .ctl_a_o(ctl_a_q), .ctl_b_o(ctl_b_q), .slip_ab_o(slip_ab), .slip_ba_o(slip_ba),
        .level_ab_o(level_ab), .level_ba_o(level_ba));
    deb_dce_model #(.PAT(16'hA5C3)) a_u (.run_rx_i(run_rx_a), .run_tx_i(run_tx_a),
        .rx_clk_o(rxc_a), .tx_clk_o(txc_a), .rxd_o(rxd_a), .txd_i(txd_a));
    deb_dce_model #(.PAT(16'h3C96)) b_u (.run_rx_i(run_rx_b), .run_tx_i(run_tx_b),
        .rx_clk_o(rxc_b), .tx_clk_o(txc_b), .rxd_o(rxd_b), .txd_i(txd_b));

    // second instance in the single-timing-clock variant, sharing the links
    deb_dual_elastic_buffer #(.BUF_BITS(BB), .X21_MODE(1'b1), .CTL_W(4)) dut_x21_u (
        .mclk_i(mclk), .arst_n_i(arst_n), .rx_clk_a_i(rxc_a), .tx_clk_a_i(txc_a),
        .rx_clk_b_i(rxc_b), .tx_clk_b_i(txc_b), .rxd_a_i(rxd_a), .rxd_b_i(rxd_b),
        .txd_a_o(txd_xa), .txd_b_o(txd_xb), .ctl_a_i(ctl_a), .ctl_b_i(ctl_b),
        .ctl_a_o(), .ctl_b_o(), .slip_ab_o(), .slip_ba_o(), .level_ab_o(), .level_ba_o());
    // each side's timing clock also samples what that side is sent
    always @(posedge rxc_a) got_xa.push_back(txd_xa);
    always @(posedge rxc_b) got_xb.push_back(txd_xb);

    // count slip pulses: ab unf, ab ovf, ba unf, ba ovf; sampled mid-cycle
    assign slip_all = {slip_ba, slip_ab};
    always @(negedge mclk)
    begin
        for (int i = 0; i < 4; i++)
            if (slip_all[i] === 1'b1) slips[i]++;
    end

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic set_run(input logic [3:0] v);
        {run_rx_a, run_tx_a, run_rx_b, run_tx_b} = v;
    endtask

    // link edges seen by the model clock that a burst runs
    function automatic int qn(input logic [3:0] run);
        case (run)
            4'h8: return a_u.sent.size();
            4'h1: return b_u.got.size();
            4'h2: return b_u.sent.size();
            default: return a_u.got.size();
        endcase
    endfunction

    task automatic do_reset();
        @(negedge mclk);
        arst_n = 1'b0;
        // link-side flops miss a reset already low at time zero until a link edge, so run the link clocks briefly
        set_run(4'hF);
        repeat (8) @(negedge mclk);
        set_run(4'h0);
        repeat (4) @(negedge mclk);
        arst_n = 1'b1;
        repeat (4) @(negedge mclk);
        slips = '{default: 0};
        got_xa.delete();
        got_xb.delete();
        a_u.sent.delete();
        a_u.got.delete();
        b_u.sent.delete();
        b_u.got.delete();
    endtask

    // idle txd_a line and centred fills after reset, control passed straight across
    task automatic t_idle_ctl();
        do_reset();
        check("level_ab", level_ab, HB);
        check("level_ba", level_ba, HB);
        check("txd_a idle", txd_a, 1);
        for (int v = 0; v < 16; v++)
        begin
            @(negedge mclk);
            ctl_a = v[3:0];
            ctl_b = ~v[3:0];
            #1;
            check("ctl_b_o", ctl_b_q, v);
            check("ctl_a_o", ctl_a_q, 4'(~v[3:0]));
        end
    endtask

    // both directions at once: half a buffer of ones plus the prefetched bit, then the stream
    task automatic t_stream();
        do_reset();
        set_run(4'hF);
        for (int k = 0; k < 9999 && (a_u.got.size() < 96 || b_u.got.size() < 96
            || got_xa.size() < 96 || got_xb.size() < 96); k++)
            @(negedge mclk);
        set_run(4'h0);
        for (int i = 0; i < 96; i++)
        begin
            check("txd_b", b_u.got[i], i <= HB ? 1'b1 : a_u.sent[i - HB - 1]);
            check("txd_a", a_u.got[i], i <= HB ? 1'b1 : b_u.sent[i - HB - 1]);
            // single timing clock: its first rising edge comes before any launch
            check("x21 txd_b", got_xb[i], i < HB + 2 ? 1'b1 : a_u.sent[i - HB - 2]);
            check("x21 txd_a", got_xa[i], i < HB + 2 ? 1'b1 : b_u.sent[i - HB - 2]);
        end
        check("slips", slips.sum(), 0);
    endtask

    // one side alone for 40 bits: one slip, then fill moves 7 from centre
    task automatic t_slip(input logic [3:0] run, input int slot, input int lab, input int lba);
        do_reset();
        set_run(run);
        for (int k = 0; k < 9999 && qn(run) < 40; k++)
            @(negedge mclk);
        set_run(4'h0);
        repeat (20) @(negedge mclk);
        check("slip kind", slips[slot], 1);
        check("slip total", slips.sum(), 1);
        check("level_ab", level_ab, lab);
        check("level_ba", level_ba, lba);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // about 14 us of traffic expected; cut off well beyond that
    initial
    begin
        #200us;
        miscompares++;
        end_of_test();
    end

    initial
    begin
        t_idle_ctl();
        t_stream();
        t_slip(4'h8, 1, HB + 7, HB);
        t_slip(4'h1, 0, HB - 7, HB);
        t_slip(4'h2, 3, HB, HB + 7);
        t_slip(4'h4, 2, HB, HB - 7);
        end_of_test();
    end
endmodule

`default_nettype wire
